// [sesst_regs.svh]
// timing counts, bus command codes and unlock addresses for the erase sequencer
`ifndef SESST_REGS_SVH
`define SESST_REGS_SVH
`define SESST_CLK_MHZ 250
`define SESST_WIN_US 50
`define SESST_WIN_CYC (`SESST_WIN_US * `SESST_CLK_MHZ)
`define SESST_WE_LOW_CYC 4'h4
`define SESST_RD_CYC 4'h8
`define SESST_RST_LOW_CYC 8'h80
`define SESST_RST_REC_CYC 8'h40
`define SESST_ADD_GUARD 16'h0008 // an add write needs seven cycles to reach its strobe rise
`define SESST_UNLK1_ADDR 21'h000555
`define SESST_UNLK2_ADDR 21'h0002aa
`define SESST_UNLK1_DATA 8'haa
`define SESST_UNLK2_DATA 8'h55
`define SESST_SETUP_DATA 8'h80
`define SESST_SECT_DATA 8'h30
`define SESST_SUSP_DATA 8'hb0
`define SESST_RESUME_DATA 8'h30
`define SESST_POLL_BIT 7
`endif

// [sesst_pkg.sv]
// types shared by the erase sequencer
package sesst_pkg;
  typedef enum logic [2:0] {
    SESST_OP_ERASE = 3'h0,
    SESST_OP_ADD = 3'h1,
    SESST_OP_SUSPEND = 3'h2,
    SESST_OP_RESUME = 3'h3,
    SESST_OP_POLL = 3'h4,
    SESST_OP_RESET = 3'h5
  } sesst_op_t;
  typedef struct packed {
    sesst_op_t op;
    logic [20:0] addr;
  } sesst_cmd_t;
  typedef struct packed {
    logic err;
    logic [15:0] status;
    logic [15:0] data;
  } sesst_rsp_t;
  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic reset_n;
    logic [20:0] addr;
  } sesst_bus_t;
endpackage : sesst_pkg

// [sesst_ctrl.sv]
// host-side sector erase, suspend, resume and status polling sequencer
//
// Contract
// RQ1 - erase is six ordered writes ending sector
// RQ2 - device preprograms itself; host sends nothing extra
// RQ3 - device holds acceptance window after final write
// RQ4 - extra sectors only while gap under window
// RQ5 - host holds interrupts off while loading sectors
// RQ6 - other command in window cancels; resend all
// RQ7 - device ignores all but suspend once erasing
// RQ8 - hardware reset aborts; reissue after read mode
// RQ9 - finished erase returns bank to array reads
// RQ10 - other bank stays readable during erase
// RQ11 - suspend is b0 at bank, erase only
// RQ12 - device suspends within 20us, window ends at once
// RQ13 - suspended sectors read status, others normal
// RQ14 - suspended program returns to suspend-read
// RQ15 - identification allowed in suspend-read mode
// RQ16 - resume at bank address, no extra resumes
// RQ17 - program polling read at program address
// RQ18 - protected program shows busy about 1us
// RQ19 - erase polling bit 0 busy, 1 done
// RQ20 - all protected sectors busy about 100us
// RQ21 - polling bit early; read again for data
// RQ22 - ready_busy_out low while erasing or programming
// RQ23 - erase_window_flag 0 open, 1 erase begun
// RQ24 - toggle_status_bit inverts while operation runs
// RQ25 - sector_toggle_bit inverts in selected sectors
// RQ26 - timeout_failure_flag set needs reset command
// RQ27 - device times window from free-running base
`timescale 1ns/1ps
`include "sesst_regs.svh"
module sesst_ctrl
  import sesst_pkg::*;
#(
  parameter int WIN_CYC = `SESST_WIN_CYC
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic en,
  input wire logic cmd_valid,
  input wire sesst_cmd_t cmd,
  output logic cmd_ready,
  output logic rsp_valid,
  output sesst_rsp_t rsp,
  output sesst_bus_t bus,
  input wire logic [15:0] dq_i,
  output logic [15:0] dq_o,
  output logic dq_oe_n,
  input wire logic ready_busy_out,
  output logic dev_busy,
  output logic window_open,
  output logic irq_hold,
  output logic erase_active,
  output logic suspended
);
  // one-hot sequencer states
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_SETUP = 7'h02,
    ST_WE_LOW = 7'h04,
    ST_HOLD = 7'h08,
    ST_READ = 7'h10,
    ST_RST_LOW = 7'h20,
    ST_RST_REC = 7'h40
  } sesst_st_t;

  sesst_st_t st_q, st_d; // sequencer state
  sesst_op_t op_q; // operation in progress
  logic [20:0] caddr_q; // address given with the order
  logic [2:0] step_q; // index of the current bus cycle
  logic [7:0] tmr_q; // cycle counter inside one bus cycle
  logic [15:0] win_q; // cycles since last sector write
  logic rd_two_q; // second read of a poll pair
  logic [15:0] first_q; // first poll read
  logic erase_q, susp_q, wopen_q; // host view of device mode
  sesst_bus_t bus_q;
  logic [15:0] dq_o_q;
  logic dq_oe_n_q, cmd_ready_q, rsp_valid_q, busy_q;
  sesst_rsp_t rsp_q;

  // address and data of one write of a script
  function automatic logic [28:0] step_word(input sesst_op_t op, input logic [2:0] s,
                                            input logic [20:0] a);
    logic [28:0] w;
    w = {`SESST_UNLK1_ADDR, `SESST_UNLK1_DATA};
    unique case (op)
      SESST_OP_ERASE: begin
        unique case (s)
          3'h0: w = {`SESST_UNLK1_ADDR, `SESST_UNLK1_DATA};
          3'h1: w = {`SESST_UNLK2_ADDR, `SESST_UNLK2_DATA};
          3'h2: w = {`SESST_UNLK1_ADDR, `SESST_SETUP_DATA};
          3'h3: w = {`SESST_UNLK1_ADDR, `SESST_UNLK1_DATA};
          3'h4: w = {`SESST_UNLK2_ADDR, `SESST_UNLK2_DATA};
          default: w = {a, `SESST_SECT_DATA};
        endcase
      end
      SESST_OP_ADD: w = {a, `SESST_SECT_DATA};
      SESST_OP_SUSPEND: w = {a, `SESST_SUSP_DATA};
      SESST_OP_RESUME: w = {a, `SESST_RESUME_DATA};
      default: w = {a, 8'h00};
    endcase
    return w;
  endfunction : step_word

  // decoded script position and order checks
  wire [28:0] first_word = step_word(cmd.op, 3'h0, cmd.addr); // first write of a new order
  wire [28:0] nxt_word = step_word(op_q, step_q + 3'h1, caddr_q); // RQ1
  wire last_step = (op_q != SESST_OP_ERASE) || (step_q == 3'h5); // RQ1
  wire take = cmd_valid && cmd_ready_q;
  wire win_live = wopen_q && (win_q < 16'(WIN_CYC) - `SESST_ADD_GUARD); // RQ4
  wire bad_add = (cmd.op == SESST_OP_ADD) && !win_live; // RQ4
  wire bad_susp = (cmd.op == SESST_OP_SUSPEND) && (!erase_q || susp_q); // RQ11
  wire bad_res = (cmd.op == SESST_OP_RESUME) && !susp_q; // RQ16
  wire bad_erase = (cmd.op == SESST_OP_ERASE) && erase_q; // RQ7
  wire refuse = bad_add || bad_susp || bad_res || bad_erase;
  wire is_write = (cmd.op == SESST_OP_ERASE) || (cmd.op == SESST_OP_ADD) ||
                  (cmd.op == SESST_OP_SUSPEND) || (cmd.op == SESST_OP_RESUME);
  wire tmr_done = (tmr_q == 8'h00);
  wire sect_write_end = st_q == ST_HOLD && last_step &&
                        (op_q == SESST_OP_ERASE || op_q == SESST_OP_ADD);
  wire poll_bit = dq_i[`SESST_POLL_BIT];
  wire rd_gap = (st_q == ST_READ) && tmr_done && !rd_two_q; // RQ21

  // next state of the bus sequencer
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      ST_IDLE: begin
        if (take && !refuse) begin
          if (is_write) begin
            st_d = ST_SETUP;
          end else if (cmd.op == SESST_OP_POLL) begin
            st_d = ST_READ;
          end else begin
            st_d = ST_RST_LOW;
          end
        end
      end
      ST_SETUP: st_d = ST_WE_LOW;
      ST_WE_LOW: begin
        if (tmr_done) begin
          st_d = ST_HOLD;
        end
      end
      ST_HOLD: st_d = last_step ? ST_IDLE : ST_SETUP;
      ST_READ: begin
        if (tmr_done && rd_two_q) begin
          st_d = ST_IDLE;
        end
      end
      ST_RST_LOW: begin
        if (tmr_done) begin
          st_d = ST_RST_REC;
        end
      end
      ST_RST_REC: begin
        if (tmr_done) begin
          st_d = ST_IDLE;
        end
      end
      default: st_d = ST_IDLE;
    endcase
  end

  // state, order latch and cycle counter
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= ST_IDLE;
      op_q <= SESST_OP_ERASE;
      caddr_q <= 21'h000000;
      step_q <= 3'h0;
      tmr_q <= 8'h00;
      rd_two_q <= 1'b0;
      first_q <= 16'h0000;
    end else if (en) begin
      st_q <= st_d;
      if (st_q == ST_IDLE && take) begin
        op_q <= cmd.op;
        caddr_q <= cmd.addr;
        step_q <= 3'h0;
        rd_two_q <= 1'b0;
        tmr_q <= (cmd.op == SESST_OP_RESET) ? `SESST_RST_LOW_CYC : 8'(`SESST_RD_CYC);
      end else if (st_q == ST_SETUP) begin
        tmr_q <= 8'(`SESST_WE_LOW_CYC);
      end else if (st_q == ST_HOLD) begin
        step_q <= step_q + 3'h1;
      end else if (st_q == ST_READ && tmr_done) begin
        first_q <= dq_i; // RQ21
        rd_two_q <= 1'b1;
        tmr_q <= 8'(`SESST_RD_CYC);
      end else if (st_q == ST_RST_LOW && tmr_done) begin
        tmr_q <= `SESST_RST_REC_CYC;
      end else if (!tmr_done) begin
        tmr_q <= tmr_q - 8'h01;
      end
    end
  end

  // device bus pins driven from flip-flops
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bus_q <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, reset_n: 1'b1, addr: 21'h000000};
      dq_o_q <= 16'h0000;
      dq_oe_n_q <= 1'b1;
    end else if (en) begin
      bus_q.reset_n <= !(st_d == ST_RST_LOW); // RQ8
      bus_q.ce_n <= !(st_d == ST_SETUP || st_d == ST_WE_LOW || st_d == ST_HOLD ||
                      st_d == ST_READ);
      bus_q.we_n <= !(st_d == ST_WE_LOW);
      bus_q.oe_n <= !(st_d == ST_READ) || rd_gap; // RQ21
      dq_oe_n_q <= !(st_d == ST_SETUP || st_d == ST_WE_LOW || st_d == ST_HOLD);
      if (st_d == ST_SETUP) begin
        bus_q.addr <= (st_q == ST_IDLE) ? first_word[28:8] : nxt_word[28:8];
        dq_o_q <= {8'h00, (st_q == ST_IDLE) ? first_word[7:0] : nxt_word[7:0]};
      end else if (st_d == ST_READ && st_q == ST_IDLE) begin
        bus_q.addr <= cmd.addr; // RQ17 RQ19
      end
    end
  end

  // host view of the erase: window timer, suspend and activity flags
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      win_q <= 16'h0000;
      wopen_q <= 1'b0;
      erase_q <= 1'b0;
      susp_q <= 1'b0;
    end else if (en) begin
      if (sect_write_end) begin
        win_q <= 16'h0000; // RQ4
        wopen_q <= 1'b1;
        erase_q <= 1'b1;
      end else if (wopen_q && win_q >= 16'(WIN_CYC - 1)) begin
        wopen_q <= 1'b0; // RQ23
      end else if (wopen_q) begin
        win_q <= win_q + 16'h0001;
      end
      if (st_q == ST_HOLD && op_q == SESST_OP_SUSPEND) begin
        susp_q <= 1'b1; // RQ12
        wopen_q <= 1'b0;
      end else if (st_q == ST_HOLD && op_q == SESST_OP_RESUME) begin
        susp_q <= 1'b0; // RQ16
      end
      if (st_q == ST_READ && tmr_done && rd_two_q && first_q[`SESST_POLL_BIT] &&
          poll_bit && !susp_q && !wopen_q && ready_busy_out) begin
        erase_q <= 1'b0; // RQ19 RQ9
      end
      if (st_q == ST_RST_LOW) begin
        erase_q <= 1'b0; // RQ8
        susp_q <= 1'b0;
        wopen_q <= 1'b0;
      end
    end
  end

  // order handshake and answers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cmd_ready_q <= 1'b0;
      rsp_valid_q <= 1'b0;
      rsp_q <= '0;
      busy_q <= 1'b0;
    end else if (en) begin
      busy_q <= !ready_busy_out; // RQ22
      cmd_ready_q <= (st_d == ST_IDLE) && !(take && refuse) && !(st_q == ST_IDLE && take);
      rsp_valid_q <= 1'b0;
      if (st_q == ST_IDLE && take && refuse) begin
        rsp_valid_q <= 1'b1; // RQ6
        rsp_q <= '{err: 1'b1, status: 16'h0000, data: 16'h0000};
      end else if (st_q != ST_IDLE && st_d == ST_IDLE) begin
        rsp_valid_q <= 1'b1;
        rsp_q <= '{err: 1'b0, status: (op_q == SESST_OP_POLL) ? first_q : 16'h0000,
                   data: (op_q == SESST_OP_POLL) ? dq_i : 16'h0000}; // RQ21
      end
    end
  end

  // outputs straight from flip-flops
  assign cmd_ready = cmd_ready_q;
  assign rsp_valid = rsp_valid_q;
  assign rsp = rsp_q;
  assign bus = bus_q;
  assign dq_o = dq_o_q;
  assign dq_oe_n = dq_oe_n_q;
  assign dev_busy = busy_q;
  assign window_open = wopen_q;
  assign irq_hold = wopen_q; // RQ5
  assign erase_active = erase_q;
  assign suspended = susp_q;
endmodule : sesst_ctrl

// [sesst_none.sv]
// holds no logic: the whole sequencer sits in the controller file

// [sesst_ctrl_sva.sv]
// concurrent checks on the erase sequencer top ports
`timescale 1ns/1ps
module sesst_ctrl_sva
  import sesst_pkg::*;
#(
  parameter int WIN_CYC = 12500
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic en,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic rsp_valid,
  input wire sesst_bus_t bus,
  input wire logic dq_oe_n,
  input wire logic ready_busy_out,
  input wire logic dev_busy,
  input wire logic window_open,
  input wire logic irq_hold,
  input wire logic erase_active,
  input wire logic suspended
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // write strobe: five low cycles, then back high
  sequence s_we_pulse;
    !bus.we_n [*5] ##1 bus.we_n;
  endsequence
  // device reset pulse lasts well beyond eight cycles
  sequence s_rst_pulse;
    !bus.reset_n [*8];
  endsequence
  AST_WE_LEN: assert property ($fell(bus.we_n) |-> s_we_pulse)
    else $error("write strobe width wrong");
  AST_WR_DRIVE: assert property (!bus.we_n |-> !dq_oe_n && !bus.ce_n && bus.oe_n)
    else $error("write cycle without data drive");
  AST_TAKE: assert property (en && cmd_valid && cmd_ready |=> !cmd_ready)
    else $error("ready stayed up after take");
  AST_RSP_ONE: assert property (rsp_valid |=> !rsp_valid)
    else $error("answer pulse too long");
  AST_IRQ: assert property (irq_hold == window_open)
    else $error("interrupt hold differs from window");
  AST_SUSP: assert property ($rose(suspended) |-> !window_open && erase_active)
    else $error("suspend left window open");
  AST_RST_LEN: assert property ($fell(bus.reset_n) |-> s_rst_pulse)
    else $error("device reset pulse too short");
  AST_RST_CLR: assert property ($rose(bus.reset_n) |-> ##[0:80] !erase_active && !suspended)
    else $error("erase state kept after reset");
  AST_BUSY: assert property (en && $past(en) |-> dev_busy == !$past(ready_busy_out))
    else $error("busy flag not following pin");
endmodule : sesst_ctrl_sva
bind sesst_ctrl sesst_ctrl_sva #(.WIN_CYC(WIN_CYC)) sesst_ctrl_sva_inst (.clk(clk),
  .arst_n(arst_n), .en(en), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
  .rsp_valid(rsp_valid), .bus(bus), .dq_oe_n(dq_oe_n), .ready_busy_out(ready_busy_out),
  .dev_busy(dev_busy), .window_open(window_open), .irq_hold(irq_hold),
  .erase_active(erase_active), .suspended(suspended));

// [sesst_flash_model.sv]
// behavioural flash bank: erase sequence, window, suspend and status reads
`timescale 1ns/1ps
module sesst_flash_model
  import sesst_pkg::*;
#(
  parameter int WIN = 200,
  parameter int ERS = 300
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire sesst_bus_t bus,
  input wire logic [15:0] dq_o,
  output logic [15:0] dq_i,
  output logic rb_oe_n
);
  logic we_q, oe_q, win, ers, susp, tog, stog; // strobe history and mode flags
  logic [63:0] sel; // sectors chosen for erasure
  logic [2:0] nwr; // writes seen of the six-write sequence
  int cnt, ecnt; // window and erase time bases
  wire [7:0] wd = dq_o[7:0];
  wire in_sel = sel[bus.addr[20:15]]; // read address inside a chosen sector
  // status byte: polling, toggle, no timeout, window flag, sector toggle
  wire [15:0] st = {8'h00, susp, tog, 1'b0, 1'b0, ers, stog, 2'b00};
  // chosen sectors read status, every other address reads erased array data
  wire [15:0] rd = ((win | ers | susp) && in_sel) ? st : 16'hffff;
  // command decode on write strobe rise, timers otherwise
  always_ff @(posedge clk) begin
    we_q <= bus.we_n;
    oe_q <= bus.oe_n;
    rb_oe_n <= !(win | ers);
    if (!arst_n || !bus.reset_n) begin
      {win, ers, susp, tog, stog, sel, nwr, dq_i} <= '0;
    end else begin
      dq_i <= bus.oe_n ? ~dq_i : rd; // released bus never keeps old data
      if (oe_q && !bus.oe_n && (win | ers)) tog <= ~tog;
      if (oe_q && !bus.oe_n && (win | ers | susp) && in_sel) stog <= ~stog;
      if (!we_q && bus.we_n) begin
        if (ers) begin
          if (wd == 8'hb0) {ers, susp} <= 2'b01;
        end else if (win) begin
          if (wd == 8'h30) begin
            cnt <= WIN;
            sel[bus.addr[20:15]] <= 1'b1;
          end else if (wd == 8'hb0) {win, susp} <= 2'b01;
          else win <= 1'b0;
        end else if (susp) begin
          // only resume is decoded: no program or id order reaches a suspended bank
          if (wd == 8'h30) {susp, ers} <= 2'b01;
        end else if (nwr == 3'h5) begin
          nwr <= 3'h0;
          win <= (wd == 8'h30);
          sel <= 64'h1 << bus.addr[20:15];
          cnt <= WIN;
          // erase time covers the bank's own preprogram; no sector is protected
          ecnt <= ERS;
        end else nwr <= nwr + 3'h1;
      end else if (win) begin
        cnt <= cnt - 1;
        if (cnt == 1) {win, ers} <= 2'b01;
      end else if (ers) begin
        ecnt <= ecnt - 1;
        if (ecnt == 1) begin
          ers <= 1'b0;
          sel <= '0;
        end
      end
    end
  end
endmodule : sesst_flash_model

// [testbench.sv]
// self-checking bench for the sector erase sequencer
`timescale 1ns/1ps
module testbench;
  import sesst_pkg::*;
  localparam int WIN = 200;
  logic clk, arst_n, en, cmd_valid, cmd_ready, rsp_valid, dq_oe_n, rb_oe_n;
  logic dev_busy, window_open, irq_hold, erase_active, suspended;
  sesst_cmd_t cmd;
  sesst_rsp_t rsp, got;
  sesst_bus_t bus;
  logic [15:0] dq_i, dq_o;
  logic [20:0] sa;
  int err_total, cmp_count;
  wire rdy = rb_oe_n ? 1'b1 : 1'b0; // pull-up on the ready pin
  sesst_ctrl #(.WIN_CYC(WIN)) sesst_ctrl_inst (.clk(clk), .arst_n(arst_n), .en(en),
    .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
    .rsp(rsp), .bus(bus), .dq_i(dq_i), .dq_o(dq_o), .dq_oe_n(dq_oe_n),
    .ready_busy_out(rdy), .dev_busy(dev_busy), .window_open(window_open),
    .irq_hold(irq_hold), .erase_active(erase_active), .suspended(suspended));
  sesst_flash_model #(.WIN(WIN)) sesst_flash_model_inst (.clk(clk), .arst_n(arst_n),
    .bus(bus), .dq_o(dq_o), .dq_i(dq_i), .rb_oe_n(rb_oe_n));
  // value compare
  task automatic chk(input string what, input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %0t %s got %h exp %h", $time, what, g, e);
    end
  endtask : chk
  // expected polling bit: low while erase runs
  function automatic logic poll_exp(input logic running);
    return !running;
  endfunction : poll_exp
  // present one order, hold until taken, wait for the answer
  task automatic issue(input sesst_op_t op, input logic [20:0] a);
    int n;
    n = 0;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd <= '{op, a};
    do @(negedge clk); while (cmd_ready !== 1'b1 && ++n < 500);
    @(posedge clk);
    cmd_valid <= 1'b0;
    do @(negedge clk); while (rsp_valid !== 1'b1 && ++n < 2000);
    if (n >= 2000) chk("answer", 16'h0, 16'h1);
    got = rsp;
  endtask : issue
  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : close_out
  // free-running clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // watchdog
  initial begin
    #(4 * 20000);
    err_total++;
    close_out();
  end
  initial begin
    {arst_n, cmd_valid, cmd, err_total, cmp_count} = '0;
    en = 1'b1;
    void'($urandom(32'h608b2d94));
    sa = 21'($urandom_range(1, 62)) << 15;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    issue(SESST_OP_SUSPEND, 21'h0); chk("idle suspend", got.err, 1'b1);
    issue(SESST_OP_RESUME, 21'h0); chk("idle resume", got.err, 1'b1);
    issue(SESST_OP_ADD, sa); chk("idle add", got.err, 1'b1);
    $display("test refusals done");
    issue(SESST_OP_ERASE, sa); chk("erase", got.err, 1'b0);
    chk("irq hold", irq_hold, 1'b1);
    issue(SESST_OP_ADD, sa + 21'h008000); chk("add", got.err, 1'b0);
    issue(SESST_OP_POLL, sa); chk("flag open", got.status[3], 1'b0);
    issue(SESST_OP_SUSPEND, sa); chk("suspend", suspended, 1'b1);
    chk("window", window_open, 1'b0);
    issue(SESST_OP_POLL, sa); chk("susp poll", got.status[7], 1'b1);
    chk("susp ready", dev_busy, 1'b0);
    chk("susp toggle", got.status[6] ^ got.data[6], 1'b0);
    chk("sector toggle", got.status[2] ^ got.data[2], 1'b1);
    issue(SESST_OP_SUSPEND, sa); chk("resuspend", got.err, 1'b1);
    issue(SESST_OP_RESUME, sa); chk("resume", suspended, 1'b0);
    issue(SESST_OP_RESUME, sa); chk("extra resume", got.err, 1'b1);
    issue(SESST_OP_POLL, sa); chk("run poll", got.status[7], poll_exp(1'b1));
    chk("run busy", dev_busy, 1'b1);
    chk("run toggle", got.status[6] ^ got.data[6], 1'b1);
    repeat (320) @(posedge clk);
    issue(SESST_OP_POLL, sa); chk("done data", got.data, 16'hffff);
    chk("done flag", erase_active, 1'b0);
    $display("test suspend resume done");
    issue(SESST_OP_ERASE, sa); chk("erase again", got.err, 1'b0);
    issue(SESST_OP_ERASE, sa); chk("double erase", got.err, 1'b1);
    repeat (WIN + 10) @(posedge clk);
    issue(SESST_OP_ADD, sa); chk("late add", got.err, 1'b1);
    issue(SESST_OP_POLL, sa); chk("erasing", got.status[7], poll_exp(1'b1));
    chk("flag shut", got.status[3], 1'b1);
    issue(SESST_OP_POLL, {~sa[20], sa[19:0]}); chk("other bank", got.data, 16'hffff);
    issue(SESST_OP_SUSPEND, sa); chk("run suspend", suspended, 1'b1);
    issue(SESST_OP_POLL, sa); chk("run susp poll", got.status[7], 1'b1);
    issue(SESST_OP_RESUME, sa); chk("run resume", got.err, 1'b0);
    issue(SESST_OP_RESET, 21'h0); chk("abort", erase_active, 1'b0);
    issue(SESST_OP_POLL, sa); chk("read mode", got.data, 16'hffff);
    $display("test window and reset done");
    close_out();
  end
endmodule : testbench
